// file: rtl/fsg_pkg.sv
package fsg_pkg;

  // ******************************************************
  // Register offsets
  // ******************************************************
  localparam logic [7:0] FAULT_CTRL_ADDR   = 8'h04;
  localparam logic [7:0] POS_FLAGS_ADDR    = 8'h12;
  localparam logic [7:0] NEG_FLAGS_ADDR    = 8'h13;
  localparam logic [7:0] GPIO_ADDR         = 8'h14;
  localparam logic [7:0] CLK_CTRL_ADDR     = 8'h20;
  localparam logic [7:0] IRQ_STATUS_ADDR   = 8'h21;
  localparam logic [7:0] IRQ_MASK_ADDR     = 8'h22;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int THRESH_LSB     = 5;
  localparam int THRESH_MSB     = 7;
  localparam int PIN_DATA_LSB   = 4;
  localparam int PIN_DATA_MSB   = 7;
  localparam int PIN_DIR_LSB    = 0;
  localparam int PIN_DIR_MSB    = 3;
  localparam int CLK_OUT_EN_BIT = 0;
  localparam int RATE_LSB       = 1;
  localparam int RATE_MSB       = 3;
  localparam int IRQ_POS_BIT    = 0;
  localparam int IRQ_NEG_BIT    = 1;
  localparam int IRQ_DONE_BIT   = 2;
  localparam int IRQ_PIN_BIT    = 3;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [7:0] FAULT_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST      = 8'h00;
  localparam logic [3:0] PIN_DATA_RST   = 4'h0;
  localparam logic [3:0] PIN_DIR_RST    = 4'hf;
  localparam logic [7:0] CLK_CTRL_RST   = 8'h00;
  localparam logic [3:0] IRQ_RST        = 4'h0;

  // ******************************************************
  // Sizes and timing
  // ******************************************************
  localparam int CHANNELS  = 8;
  localparam int PINS      = 4;
  localparam int SYNC_BITS = 7;
  localparam int CLK_MHZ   = 100;
  localparam int OSC_HALF_NS = 40;
  localparam int OSC_HALF_CYC = (OSC_HALF_NS * CLK_MHZ) / 1000;
  // Conversion clock ticks for the fastest data rate code
  localparam int CONV_BASE_TICKS = 16;

  // ******************************************************
  // Comparator levels on a 0 to 255 code scale
  // ******************************************************
  localparam logic [7:0] HIGH_LEVEL [8] = '{
    8'hf2, 8'hec, 8'he6, 8'hdf, 8'hd9, 8'hcc, 8'hbf, 8'hb3
  };

  // Conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_DONE
  } fsg_conv_type;

endpackage : fsg_pkg

// file: rtl/fsg_sync_if.sv
`timescale 1ns/1ns
`default_nettype none

// ******************************************************
// Raw pin levels in, two-stage synchronised levels out
// ******************************************************
interface fsg_sync_if #(parameter int W = 1);
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;

  modport src (output async_in, input sync_out);
  modport syn (input async_in, output sync_out);
endinterface : fsg_sync_if

`default_nettype wire

// file: rtl/fsg_sync.sv
`timescale 1ns/1ns
`default_nettype none

module fsg_sync (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_sys_rst,
  // Pin levels
  fsg_sync_if.syn     sif
);

  logic [$bits(sif.async_in)-1:0] meta_ff;
  logic [$bits(sif.async_in)-1:0] stable_ff;
  logic [$bits(sif.async_in)-1:0] nxt_meta;
  logic [$bits(sif.async_in)-1:0] nxt_stable;

  // Next stage values
  always_comb begin
    nxt_meta   = sif.async_in;
    nxt_stable = meta_ff;
  end

  // Two flip-flop chain
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_ff   <= '0;
      stable_ff <= '0;
    end else begin
      meta_ff   <= nxt_meta;
      stable_ff <= nxt_stable;
    end
  end

  assign sif.sync_out = stable_ff;

endmodule : fsg_sync

`default_nettype wire

// file: rtl/fsg_regs.sv
// What this block does
// - Positive fault byte, bit 7 channel 8 down to bit 0 channel 1.
// - Negative fault byte at 13h, resets to 00h, same bit order.
// - Each fault bit compares its input against the selected threshold.
// - Fault bytes are read-only, ignore writes, and are zero after reset.
// - Pin register at 14h resets to 0Fh; data 7-4, direction 3-0.
// - Direction 0 makes a pin output, 1 input; all inputs after reset.
// - Writing pin data drives output pins and does nothing for inputs.
// - Start rise to done fall is a fixed delay per data rate.
// - Only one device drives its oscillator out; others take it in.
// - Threshold field sits in bits 7-5 of 04h; 000 is 95% and 5%.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module fsg_regs (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Converter codes, channel n in bits 8n-1..8n-8
  input  wire logic [63:0] i_pos_code,
  input  wire logic [63:0] i_neg_code,
  // General-purpose pins
  input  wire logic [3:0]  i_pin_in,
  output logic      [3:0]  o_pin_out,
  output logic      [3:0]  o_pin_oe,
  // Conversion control
  input  wire logic        i_start,
  output logic             o_conversion_done_indication_n,
  // Clock sharing
  input  wire logic        i_clock_source_select_pin,
  input  wire logic        i_ext_clk,
  output logic             o_clk_out,
  output logic             o_clk_out_oe,
  // Interrupt
  output logic             o_irq
);

  // ******************************************************
  // Pin synchronisers
  // ******************************************************
  fsg_sync_if #(.W(fsg_pkg::SYNC_BITS)) pins_if ();

  assign pins_if.async_in = {i_ext_clk, i_clock_source_select_pin,
                             i_start, i_pin_in};

  fsg_sync u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .sif       (pins_if.syn)
  );

  logic [3:0] pin_level;
  logic       start_lvl;
  logic       osc_select;
  logic       ext_clk_lvl;

  // Synchronised pin levels
  assign pin_level   = pins_if.sync_out[3:0];
  assign start_lvl   = pins_if.sync_out[4];
  assign osc_select  = pins_if.sync_out[5];
  assign ext_clk_lvl = pins_if.sync_out[6];

  // ******************************************************
  // Register state
  // ******************************************************
  logic [2:0] comparator_threshold_field_ff;
  logic [2:0] nxt_threshold;
  logic [7:0] positive_input_fault_flags_ff;
  logic [7:0] nxt_pos_flags;
  logic [7:0] negative_input_fault_flags_ff;
  logic [7:0] nxt_neg_flags;
  logic [3:0] pin_data_field_ff;
  logic [3:0] nxt_pin_data;
  logic [3:0] pin_direction_field_ff;
  logic [3:0] nxt_pin_dir;
  logic       clk_out_en_ff;
  logic       nxt_clk_out_en;
  logic [2:0] rate_ff;
  logic [2:0] nxt_rate;
  logic [3:0] irq_status_ff;
  logic [3:0] nxt_irq_status;
  logic [3:0] irq_mask_ff;
  logic [3:0] nxt_irq_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] pin_prev_ff;
  logic [3:0] nxt_pin_prev;

  logic [7:0] high_lvl;
  logic [7:0] low_lvl;
  logic [3:0] irq_events;
  logic [3:0] wr_dir;
  logic       done_fall;

  // Threshold pair from the control field
  always_comb begin
    high_lvl = fsg_pkg::HIGH_LEVEL[comparator_threshold_field_ff];
    low_lvl  = 8'hff - high_lvl;
  end

  // Per-channel comparisons, channel 1 in bit 0
  always_comb begin
    for (int ch = 0; ch < fsg_pkg::CHANNELS; ch++) begin
      nxt_pos_flags[ch] = (i_pos_code[ch*8 +: 8] > high_lvl) ||
                          (i_pos_code[ch*8 +: 8] < low_lvl);
      nxt_neg_flags[ch] = (i_neg_code[ch*8 +: 8] > high_lvl) ||
                          (i_neg_code[ch*8 +: 8] < low_lvl);
    end
  end

  // Write and read decode
  always_comb begin
    nxt_threshold  = comparator_threshold_field_ff;
    nxt_pin_data   = pin_data_field_ff;
    nxt_pin_dir    = pin_direction_field_ff;
    nxt_clk_out_en = clk_out_en_ff;
    nxt_rate       = rate_ff;
    nxt_irq_mask   = irq_mask_ff;
    nxt_rdata      = 8'h00;
    nxt_pin_prev   = pin_level;
    wr_dir         = i_wdata[fsg_pkg::PIN_DIR_MSB:fsg_pkg::PIN_DIR_LSB];
    if (i_wr) begin
      unique case (i_addr)
        fsg_pkg::FAULT_CTRL_ADDR: begin
          nxt_threshold =
            i_wdata[fsg_pkg::THRESH_MSB:fsg_pkg::THRESH_LSB];
        end
        fsg_pkg::GPIO_ADDR: begin
          nxt_pin_dir = wr_dir;
          for (int p = 0; p < fsg_pkg::PINS; p++) begin
            if (!wr_dir[p]) begin
              nxt_pin_data[p] = i_wdata[fsg_pkg::PIN_DATA_LSB + p];
            end
          end
        end
        fsg_pkg::CLK_CTRL_ADDR: begin
          nxt_clk_out_en = i_wdata[fsg_pkg::CLK_OUT_EN_BIT];
          nxt_rate = i_wdata[fsg_pkg::RATE_MSB:fsg_pkg::RATE_LSB];
        end
        fsg_pkg::IRQ_MASK_ADDR: begin
          nxt_irq_mask = i_wdata[3:0];
        end
        default: begin
          // Fault bytes, status and unmapped writes are dropped
        end
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        fsg_pkg::FAULT_CTRL_ADDR: begin
          nxt_rdata = {comparator_threshold_field_ff, 5'h00};
        end
        fsg_pkg::POS_FLAGS_ADDR: nxt_rdata = positive_input_fault_flags_ff;
        fsg_pkg::NEG_FLAGS_ADDR: nxt_rdata = negative_input_fault_flags_ff;
        fsg_pkg::GPIO_ADDR: begin
          nxt_rdata = {pin_level, pin_direction_field_ff};
        end
        fsg_pkg::CLK_CTRL_ADDR: nxt_rdata = {4'h0, rate_ff, clk_out_en_ff};
        fsg_pkg::IRQ_STATUS_ADDR: nxt_rdata = {4'h0, irq_status_ff};
        fsg_pkg::IRQ_MASK_ADDR: nxt_rdata = {4'h0, irq_mask_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Sticky events; a new event wins over the read clear
  always_comb begin
    irq_events = 4'h0;
    irq_events[fsg_pkg::IRQ_POS_BIT] =
      |(nxt_pos_flags & ~positive_input_fault_flags_ff);
    irq_events[fsg_pkg::IRQ_NEG_BIT] =
      |(nxt_neg_flags & ~negative_input_fault_flags_ff);
    irq_events[fsg_pkg::IRQ_DONE_BIT] = done_fall;
    irq_events[fsg_pkg::IRQ_PIN_BIT] =
      |((pin_level ^ pin_prev_ff) & pin_direction_field_ff);
    nxt_irq_status = irq_status_ff;
    if (i_rd && (i_addr == fsg_pkg::IRQ_STATUS_ADDR)) begin
      nxt_irq_status = 4'h0;
    end
    nxt_irq_status = nxt_irq_status | irq_events;
  end

  // Register file flip-flops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      comparator_threshold_field_ff <= fsg_pkg::FAULT_CTRL_RST[7:5];
      positive_input_fault_flags_ff <= fsg_pkg::FLAGS_RST;
      negative_input_fault_flags_ff <= fsg_pkg::FLAGS_RST;
      pin_data_field_ff      <= fsg_pkg::PIN_DATA_RST;
      pin_direction_field_ff <= fsg_pkg::PIN_DIR_RST;
      clk_out_en_ff          <= fsg_pkg::CLK_CTRL_RST[0];
      rate_ff                <= fsg_pkg::CLK_CTRL_RST[3:1];
      irq_status_ff          <= fsg_pkg::IRQ_RST;
      irq_mask_ff            <= fsg_pkg::IRQ_RST;
      rdata_ff               <= 8'h00;
      pin_prev_ff            <= 4'h0;
    end else begin
      comparator_threshold_field_ff <= nxt_threshold;
      positive_input_fault_flags_ff <= nxt_pos_flags;
      negative_input_fault_flags_ff <= nxt_neg_flags;
      pin_data_field_ff      <= nxt_pin_data;
      pin_direction_field_ff <= nxt_pin_dir;
      clk_out_en_ff          <= nxt_clk_out_en;
      rate_ff                <= nxt_rate;
      irq_status_ff          <= nxt_irq_status;
      irq_mask_ff            <= nxt_irq_mask;
      rdata_ff               <= nxt_rdata;
      pin_prev_ff            <= nxt_pin_prev;
    end
  end

  // ******************************************************
  // Pin drivers and interrupt
  // ******************************************************
  assign o_pin_out = pin_data_field_ff;
  assign o_pin_oe  = ~pin_direction_field_ff;
  assign o_rdata   = rdata_ff;
  assign o_irq     = |(irq_status_ff & irq_mask_ff);

  // ******************************************************
  // Oscillator, shared clock and conversion timing
  // ******************************************************
  logic [7:0]           osc_cnt_ff;
  logic [7:0]           nxt_osc_cnt;
  logic                 osc_ff;
  logic                 nxt_osc;
  logic                 ext_prev_ff;
  logic                 start_prev_ff;
  logic                 conv_tick;
  logic                 start_rise;
  fsg_pkg::fsg_conv_type conv_ff;
  fsg_pkg::fsg_conv_type nxt_conv;
  logic [11:0]          conv_cnt_ff;
  logic [11:0]          nxt_conv_cnt;
  logic [11:0]          conv_len;
  logic                 done_n_ff;
  logic                 nxt_done_n;

  // Internal oscillator from the system clock
  always_comb begin
    nxt_osc_cnt = osc_cnt_ff + 8'h01;
    nxt_osc     = osc_ff;
    if (osc_cnt_ff == 8'(fsg_pkg::OSC_HALF_CYC - 1)) begin
      nxt_osc_cnt = 8'h00;
      nxt_osc     = ~osc_ff;
    end
  end

  // Tick from the selected conversion clock
  always_comb begin
    start_rise = start_lvl && !start_prev_ff;
    if (osc_select) begin
      conv_tick = nxt_osc && !osc_ff;
    end else begin
      conv_tick = ext_clk_lvl && !ext_prev_ff;
    end
    conv_len = 12'(fsg_pkg::CONV_BASE_TICKS) << rate_ff;
  end

  // Fixed delay from start rise to done fall
  always_comb begin
    nxt_conv     = conv_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_done_n   = done_n_ff;
    done_fall    = 1'b0;
    if (start_rise) begin
      nxt_conv     = fsg_pkg::CONV_RUN;
      nxt_conv_cnt = 12'h000;
      nxt_done_n   = 1'b1;
    end else begin
      unique case (conv_ff)
        fsg_pkg::CONV_IDLE: begin
        end
        fsg_pkg::CONV_RUN: begin
          if (conv_tick) begin
            nxt_conv_cnt = conv_cnt_ff + 12'h001;
            if (conv_cnt_ff == conv_len - 12'h001) begin
              nxt_conv   = fsg_pkg::CONV_DONE;
              nxt_done_n = 1'b0;
              done_fall  = 1'b1;
            end
          end
        end
        fsg_pkg::CONV_DONE: begin
        end
      endcase
    end
  end

  // Timing flip-flops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      osc_cnt_ff    <= 8'h00;
      osc_ff        <= 1'b0;
      ext_prev_ff   <= 1'b0;
      start_prev_ff <= 1'b0;
      conv_ff       <= fsg_pkg::CONV_IDLE;
      conv_cnt_ff   <= 12'h000;
      done_n_ff     <= 1'b1;
    end else begin
      osc_cnt_ff    <= nxt_osc_cnt;
      osc_ff        <= nxt_osc;
      ext_prev_ff   <= ext_clk_lvl;
      start_prev_ff <= start_lvl;
      conv_ff       <= nxt_conv;
      conv_cnt_ff   <= nxt_conv_cnt;
      done_n_ff     <= nxt_done_n;
    end
  end

  // Oscillator drives out only on the clock source device
  assign o_clk_out    = osc_ff & osc_select & clk_out_en_ff;
  assign o_clk_out_oe = osc_select & clk_out_en_ff;
  assign o_conversion_done_indication_n = done_n_ff;

endmodule : fsg_regs

`default_nettype wire

// file: testbench/fsg_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module fsg_regs_monitor (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  // Pins, conversion and clock sharing
  input  wire logic [3:0] o_pin_out,
  input  wire logic [3:0] o_pin_oe,
  input  wire logic       i_start,
  input  wire logic       o_conversion_done_indication_n,
  input  wire logic       o_clk_out,
  input  wire logic       o_clk_out_oe,
  input  wire logic       o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ****************************************
  // Sequences
  // ****************************************
  sequence s_gpio_wr;
    i_wr && i_addr == fsg_pkg::GPIO_ADDR;
  endsequence
  sequence s_start_rise;
    $rose(i_start) && !o_conversion_done_indication_n;
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  oe_dir_a: assert property (
    s_gpio_wr |=> o_pin_oe == ~$past(i_wdata[3:0]))
    else $error("pin enables do not follow direction write");
  out_load_a: assert property (
    s_gpio_wr |=> (o_pin_out & ~$past(i_wdata[3:0])) ==
      ($past(i_wdata[7:4]) & ~$past(i_wdata[3:0])))
    else $error("output pin level not loaded");
  out_keep_a: assert property (
    s_gpio_wr |=> (o_pin_out & $past(i_wdata[3:0])) ==
      ($past(o_pin_out) & $past(i_wdata[3:0])))
    else $error("input pin level changed by write");
  dir_read_a: assert property (
    i_rd && i_addr == fsg_pkg::GPIO_ADDR |=>
      o_rdata[3:0] == ~$past(o_pin_oe))
    else $error("direction bits read back wrong");
  rd_idle_a: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read answer");
  rst_val_a: assert property (
    $fell(i_sys_rst) |-> o_pin_oe == 4'h0 && !o_irq &&
      o_conversion_done_indication_n)
    else $error("outputs wrong after reset");
  done_rise_a: assert property (
    s_start_rise |-> ##[1:6] o_conversion_done_indication_n)
    else $error("start rise not answered");
  done_hold_a: assert property (
    $rose(o_conversion_done_indication_n) |=>
      o_conversion_done_indication_n [*8])
    else $error("conversion ended too early");
  clk_gate_a: assert property (
    !o_clk_out_oe |-> !o_clk_out)
    else $error("clock out toggles while not driven");
  clk_half_a: assert property (
    o_clk_out_oe && $past(o_clk_out_oe) && $rose(o_clk_out) |=>
      (o_clk_out || !o_clk_out_oe) [*3])
    else $error("shared clock high phase too short");
endmodule : fsg_regs_monitor

bind fsg_regs fsg_regs_monitor u_fsg_regs_monitor (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_start(i_start),
  .o_conversion_done_indication_n(o_conversion_done_indication_n),
  .o_clk_out(o_clk_out), .o_clk_out_oe(o_clk_out_oe), .o_irq(o_irq)
);

`default_nettype wire

// file: testbench/fsg_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

module fsg_pin_model (
  // Design pin drive
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_oe,
  // Far-side levels for pins the design leaves alone
  input  wire logic [3:0] i_far_level,
  // Resolved pins and shared conversion clock
  output logic      [3:0] o_pin_level,
  output logic            o_ext_clk
);
  // Each pin shows whichever side drives it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pin_level[i] = i_pin_oe[i] ? i_pin_out[i] : i_far_level[i];
    end
  end

  // Clock from the device that owns the oscillator
  initial begin
    o_ext_clk = 1'b0;
    forever #40 o_ext_clk = ~o_ext_clk;
  end
endmodule : fsg_pin_model

`default_nettype wire

// file: testbench/fsg_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module fsg_regs_bench;
  logic        clk, rst, wr, rd, start, sel, ext_clk, clk_out, clk_oe;
  logic        done_n, irq;
  logic        rd_q = 1'b0;
  logic [7:0]  addr, wdata, rdata, d, hi;
  logic [63:0] pos, neg, pc, nc;
  logic [3:0]  far, lvl, pout, poe, omod;
  logic [15:0] expq[$];
  logic [15:0] note;
  int          errors, n_tests, cyc;
  integer      seed = 32'h34b05898;

  fsg_regs u_fsg_regs (
    .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pos_code(pos),
    .i_neg_code(neg), .i_pin_in(lvl), .o_pin_out(pout), .o_pin_oe(poe),
    .i_start(start), .o_conversion_done_indication_n(done_n),
    .i_clock_source_select_pin(sel), .i_ext_clk(ext_clk),
    .o_clk_out(clk_out), .o_clk_out_oe(clk_oe), .o_irq(irq)
  );
  fsg_pin_model u_fsg_pin_model (
    .i_pin_out(pout), .i_pin_oe(poe), .i_far_level(far),
    .o_pin_level(lvl), .o_ext_clk(ext_clk)
  );

  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, e, m);
    expq.push_back({e & m, m});
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg

  function automatic logic [7:0] flags(input logic [63:0] c, input int t);
    logic [7:0] h;
    logic [7:0] f;
    h = fsg_pkg::HIGH_LEVEL[t];
    for (int i = 0; i < 8; i++) begin
      f[i] = c[8*i+:8] > h || c[8*i+:8] < 8'hff - h;
    end
    return f;
  endfunction : flags

  // Start a conversion and time the done fall
  task automatic conv(input logic s, input logic [2:0] r);
    int n;
    n   = 0;
    sel <= s;
    wr_reg(fsg_pkg::CLK_CTRL_ADDR, {4'h0, r, 1'b1});
    repeat (4) @(posedge clk);
    `CHK("clk_oe", s, clk_oe)
    start <= 1'b1;
    while (done_n !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (done_n !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    `CHK("delay", 1'b1, n >= (128 << r) - 8 && n <= (128 << r) + 16)
    start <= 1'b0;
  endtask : conv

  task test_done;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read answer checker and cycle limit
  always @(posedge clk) begin
    rd_q <= rd;
    cyc++;
    if (rd_q) begin
      note = expq.pop_front();
      `CHK("rdata", note[15:8], rdata & note[7:0])
    end
    if (cyc == 6000) begin
      errors++;
      test_done;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, wr, rd, start, sel, addr, wdata} = {1'b1, 20'h0};
    pos  = {8{8'h80}};
    neg  = {8{8'h80}};
    far  = 4'h9;
    omod = 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(fsg_pkg::POS_FLAGS_ADDR, 8'h00, 8'hff);
    rd_reg(fsg_pkg::NEG_FLAGS_ADDR, 8'h00, 8'hff);
    rd_reg(fsg_pkg::GPIO_ADDR, 8'h9f, 8'hff);
    wr_reg(fsg_pkg::POS_FLAGS_ADDR, 8'hff);
    wr_reg(fsg_pkg::NEG_FLAGS_ADDR, 8'hff);
    rd_reg(fsg_pkg::POS_FLAGS_ADDR, 8'h00, 8'hff);
    rd_reg(fsg_pkg::NEG_FLAGS_ADDR, 8'h00, 8'hff);
    rd_reg(8'h3c, 8'h00, 8'hff);
    $display("test reset and read-only done");
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'h5a : (i == 1) ? 8'h0f :
          (i == 2) ? 8'h0a : 8'($random(seed));
      if (i > 2)
        far <= 4'($random(seed));
      wr_reg(fsg_pkg::GPIO_ADDR, d);
      omod = (omod & d[3:0]) | (d[7:4] & ~d[3:0]);
      repeat (3) @(posedge clk);
      `CHK("pin_oe", ~d[3:0], poe)
      `CHK("pin_out", omod, pout)
      rd_reg(fsg_pkg::GPIO_ADDR,
             {(~d[3:0] & omod) | (d[3:0] & far), d[3:0]},
             8'hff);
    end
    $display("test pins done");
    for (int t = 0; t < 8; t++) begin
      pc = {$random(seed), $random(seed)};
      nc = {$random(seed), $random(seed)};
      hi = fsg_pkg::HIGH_LEVEL[t];
      pc[7:0]   = hi;
      pc[63:56] = hi + 8'h01;
      nc[7:0]   = 8'hfe - hi;
      nc[63:56] = 8'hff - hi;
      pos <= pc;
      neg <= nc;
      wr_reg(fsg_pkg::FAULT_CTRL_ADDR, {t[2:0], 5'h00});
      rd_reg(fsg_pkg::POS_FLAGS_ADDR, flags(pc, t), 8'hff);
      rd_reg(fsg_pkg::NEG_FLAGS_ADDR, flags(nc, t), 8'hff);
    end
    $display("test fault flags done");
    pos <= {8{8'h80}};
    neg <= {8{8'h80}};
    wr_reg(fsg_pkg::IRQ_MASK_ADDR, 8'h00);
    rd_reg(fsg_pkg::IRQ_STATUS_ADDR, 8'h00, 8'h00);
    pos <= {{7{8'h80}}, 8'hff};
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    wr_reg(fsg_pkg::IRQ_MASK_ADDR, 8'h01);
    `CHK("irq", 1'b1, irq)
    rd_reg(fsg_pkg::IRQ_STATUS_ADDR, 8'h01, 8'hff);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    $display("test interrupt done");
    conv(1'b1, 3'h0);
    conv(1'b1, 3'h1);
    conv(1'b0, 3'h0);
    $display("test conversion timing done");
    test_done;
  end
endmodule : fsg_regs_bench

`default_nettype wire
